// ===== include/touch_adc_regs.svh
// Register map, field positions, reset values and timing counts of the converter control
// Notes on behaviour
// - Operation code selects idle, single, slave, master
// - Host writes pointer first; next read returns it
// - Channel codes 0-1 pick touch position inputs
// - Codes 3-7 auxiliary/battery; code 10 pressure one
// - Codes 8 and 9 pick temperature measurements
// - Bit 11: zero ratiometric, one single-ended
// - Repeat interval: once, 1024, 2048, 16384 periods
// - Bit 2 picks internal or external reference
// - Bit 3 sets hold pin active level
// - Settle delay: power-up, X/Y channels, precharge
// - Settle delay codes: 1, 256, 2048, 16384
// - Power policy codes gate converter and reference
// - External reference keeps internal reference off
// - Sample time: 4, 8, 16, 32 periods
// - Averaging: 1, 4, 8 or 16 per channel
// - Pointer 0x10-0x1A returns results in channel order
`ifndef TOUCH_ADC_REGS_SVH
`define TOUCH_ADC_REGS_SVH
// Write addresses and readback pointer values
`define SETUP_A_ADDR 4'h1
`define SETUP_B_ADDR 4'h2
`define PTR_SETUP_A 5'h01
`define PTR_SETUP_B 5'h02
`define PTR_RESULT_BASE 5'h10
`define RESULT_COUNT 11
`define SETUP_A_RESET 12'h000
`define SETUP_B_RESET 12'h000
// First register fields
`define OP_LSB 0
`define PTR_LSB 2
`define PTR_MSB 6
`define CHAN_LSB 7
`define CHAN_MSB 10
`define SINGLE_ENDED_BIT 11
// Second register fields
`define INTERVAL_LSB 0
`define REF_EXT_BIT 2
`define HOLD_POL_BIT 3
`define SETTLE_LSB 4
`define POWER_LSB 6
`define SAMPLE_LSB 8
`define AVERAGE_LSB 10
// Clock periods in ns; delays, sample times and intervals in converter clock periods
`define CLK_PERIOD_NS 5
`define CONV_PERIOD_NS 500
`define CONV_TICK_CYCLES ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTERVAL_1 15'h0400
`define INTERVAL_2 15'h0800
`define INTERVAL_3 15'h4000
`define SETTLE_0 15'h0001
`define SETTLE_1 15'h0100
`define SETTLE_2 15'h0800
`define SETTLE_3 15'h4000
`define SAMPLE_0 15'h0004
`define SAMPLE_1 15'h0008
`define SAMPLE_2 15'h0010
`define SAMPLE_3 15'h0020
`endif

// ===== include/touch_adc_pkg.sv
// Types shared by the converter control modules
package touch_adc_pkg;
  // Operation codes of the first register
  typedef enum logic [1:0] {OP_IDLE, OP_SINGLE, OP_SLAVE, OP_MASTER} op_mode_type;
  // Power policy codes of the second register
  typedef enum logic [1:0] {PWR_OFF, PWR_CONV, PWR_ON, PWR_ADC_CONV} power_type;
  // Conversion sequence states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_ACQUIRE, ST_CONVERT, ST_PRECHARGE, ST_REPEAT
  } state_type;
endpackage

// ===== include/conv_timer_if.sv
// Handshake between the sequencer and its converter period timer
`timescale 1ns/1ps
interface conv_timer_if;
  logic start;
  logic [14:0] length;
  logic hold;
  logic expired;
  modport ctrl (output start, output length, output hold, input expired);
  modport timer (input start, input length, input hold, output expired);
endinterface

// ===== logic/conv_timer.sv
// Converter period prescaler and down counter for delays and intervals
`timescale 1ns/1ps
`include "touch_adc_regs.svh"
module conv_timer #(
  parameter int TICK_CYCLES = `CONV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sequencer side
  conv_timer_if.timer tmr
);
  logic [15:0] pre_q;
  logic [14:0] left_q;
  logic run_q;
  logic exp_q;
  logic tick;

  // One tick per converter period
  assign tick = (pre_q == 16'(TICK_CYCLES - 1));
  assign tmr.expired = exp_q;

  // Prescaler restarts with each load so the first period is whole
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 16'h0000;
    end else if (tmr.start || tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Period counter, paused while hold is asserted
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= 15'h0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (tmr.start) begin
        left_q <= tmr.length;
        run_q <= 1'b1;
      end else if (run_q && tick && !tmr.hold) begin
        if (left_q <= 15'h0001) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end
        left_q <= left_q - 15'h0001;
      end
    end
  end
endmodule

// ===== logic/touch_adc_control.sv
// Control registers and conversion sequencer of the touch screen converter
`timescale 1ns/1ps
`include "touch_adc_regs.svh"
module touch_adc_control
  import touch_adc_pkg::*;
#(
  parameter int TICK_CYCLES = `CONV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access from the serial interface
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_wr_addr_i,
  input wire logic [11:0] reg_wr_data_i,
  input wire logic reg_rd_i,
  output logic [11:0] reg_rd_data_o,
  // Successive approximation converter
  output logic sar_start_o,
  input wire logic sar_done_i,
  input wire logic [11:0] sar_result_i,
  output logic sample_o,
  output logic [3:0] channel_select_o,
  output logic single_ended_select_o,
  output logic ref_external_o,
  output logic adc_power_o,
  output logic ref_power_o,
  // Pins
  input wire logic acquisition_hold_pin_i,
  output logic touch_irq_precharge_o,
  output logic busy_o
);
  logic [11:0] setup_a_q;
  logic [11:0] setup_b_q;
  logic [11:0] rd_data_q;
  logic [11:0] result_q [`RESULT_COUNT];
  state_type state_q;
  logic powered_q;
  logic [4:0] avg_left_q;
  logic [15:0] acc_q;
  logic sar_start_q;
  logic adc_power_q;
  logic ref_power_q;
  logic sample_q;
  logic precharge_q;
  logic tmr_start_q;
  logic [14:0] tmr_len_q;
  logic wr_a;
  logic wr_b;
  logic start_req;
  logic stop_req;
  logic hold_active;
  logic last_done;
  logic [15:0] acc_next;
  logic [15:0] avg_shifted;
  logic [3:0] chan;
  op_mode_type op_now;
  op_mode_type op_new;
  power_type pwr;

  conv_timer_if tmr_bus ();

  // Settle delay length for a code
  function automatic logic [14:0] settle_len(input logic [1:0] code);
    unique case (code)
      2'b00: settle_len = `SETTLE_0;
      2'b01: settle_len = `SETTLE_1;
      2'b10: settle_len = `SETTLE_2;
      2'b11: settle_len = `SETTLE_3;
    endcase
  endfunction

  // Timer load on entry to a state
  function automatic logic [14:0] entry_len(input state_type s, input logic [11:0] b);
    logic [14:0] len;
    len = 15'h0001;
    unique case (s)
      ST_SETTLE, ST_PRECHARGE: len = settle_len(b[`SETTLE_LSB+:2]);
      ST_ACQUIRE: begin
        unique case (b[`SAMPLE_LSB+:2])
          2'b00: len = `SAMPLE_0;
          2'b01: len = `SAMPLE_1;
          2'b10: len = `SAMPLE_2;
          2'b11: len = `SAMPLE_3;
        endcase
      end
      ST_REPEAT: begin
        unique case (b[`INTERVAL_LSB+:2])
          2'b00: len = 15'h0001;
          2'b01: len = `INTERVAL_1;
          2'b10: len = `INTERVAL_2;
          2'b11: len = `INTERVAL_3;
        endcase
      end
      ST_IDLE, ST_CONVERT: len = 15'h0001;
    endcase
    return len;
  endfunction

  // Number of conversions averaged per channel
  function automatic logic [4:0] avg_count(input logic [1:0] code);
    unique case (code)
      2'b00: avg_count = 5'h01;
      2'b01: avg_count = 5'h04;
      2'b10: avg_count = 5'h08;
      2'b11: avg_count = 5'h10;
    endcase
  endfunction

  // Settle needed after power-up and before touch position channels
  function automatic logic needs_settle(input logic [3:0] c, input logic powered);
    return !powered || (c == 4'h0) || (c == 4'h1);
  endfunction

  // First state of a conversion round
  function automatic state_type first_state(input logic [3:0] c, input logic powered);
    return needs_settle(c, powered) ? ST_SETTLE : ST_ACQUIRE;
  endfunction

  // Decoded fields of the live registers and of the register write bus
  assign op_now = op_mode_type'(setup_a_q[`OP_LSB+:2]);
  assign op_new = op_mode_type'(reg_wr_data_i[`OP_LSB+:2]);
  assign pwr = power_type'(setup_b_q[`POWER_LSB+:2]);
  assign chan = setup_a_q[`CHAN_MSB:`CHAN_LSB];
  assign wr_a = reg_wr_i && (reg_wr_addr_i == `SETUP_A_ADDR);
  assign wr_b = reg_wr_i && (reg_wr_addr_i == `SETUP_B_ADDR);

  // Start needs converter power; master sequencing is dead under always-on
  assign start_req = wr_a && (op_new != OP_IDLE) && (pwr != PWR_OFF)
                     && !((op_new == OP_MASTER) && (pwr == PWR_ON));
  assign stop_req = wr_a && (op_new == OP_IDLE);

  // Hold pin level compared against its programmed polarity
  assign hold_active = setup_b_q[`HOLD_POL_BIT] ? acquisition_hold_pin_i
                                                 : !acquisition_hold_pin_i;

  // Timer connection; acquisition is stretched while hold is active
  assign tmr_bus.start = tmr_start_q;
  assign tmr_bus.length = tmr_len_q;
  assign tmr_bus.hold = (state_q == ST_ACQUIRE) && hold_active;

  conv_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) timer_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr_bus.timer)
  );

  // Control register writes, every field kept as written
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      setup_a_q <= `SETUP_A_RESET;
      setup_b_q <= `SETUP_B_RESET;
    end else begin
      if (wr_a) begin
        setup_a_q <= reg_wr_data_i;
      end
      if (wr_b) begin
        setup_b_q <= reg_wr_data_i;
      end
    end
  end

  // Last conversion of the averaging run
  assign last_done = (state_q == ST_CONVERT) && sar_done_i && (avg_left_q <= 5'h01);

  // Sequencer; a new start restarts the round, a zero code aborts it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      tmr_start_q <= 1'b0;
      tmr_len_q <= 15'h0001;
    end else begin
      tmr_start_q <= 1'b0;
      if (stop_req) begin
        state_q <= ST_IDLE;
      end else if (start_req) begin
        state_q <= first_state(reg_wr_data_i[`CHAN_MSB:`CHAN_LSB], powered_q);
        tmr_start_q <= 1'b1;
        tmr_len_q <= entry_len(first_state(reg_wr_data_i[`CHAN_MSB:`CHAN_LSB], powered_q),
                               setup_b_q);
      end else begin
        unique case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_SETTLE: begin
            if (tmr_bus.expired) begin
              state_q <= ST_ACQUIRE;
              tmr_start_q <= 1'b1;
              tmr_len_q <= entry_len(ST_ACQUIRE, setup_b_q);
            end
          end
          ST_ACQUIRE: begin
            if (tmr_bus.expired) begin
              state_q <= ST_CONVERT;
            end
          end
          ST_CONVERT: begin
            if (sar_done_i) begin
              state_q <= last_done ? ST_PRECHARGE : ST_ACQUIRE;
              tmr_start_q <= 1'b1;
              tmr_len_q <= entry_len(last_done ? ST_PRECHARGE : ST_ACQUIRE, setup_b_q);
            end
          end
          ST_PRECHARGE: begin
            if (tmr_bus.expired) begin
              if ((op_now == OP_MASTER) && (setup_b_q[`INTERVAL_LSB+:2] != 2'b00)
                  && (pwr != PWR_ON) && (pwr != PWR_OFF)) begin
                state_q <= ST_REPEAT;
                tmr_start_q <= 1'b1;
                tmr_len_q <= entry_len(ST_REPEAT, setup_b_q);
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_REPEAT: begin
            if (tmr_bus.expired) begin
              state_q <= first_state(chan, powered_q);
              tmr_start_q <= 1'b1;
              tmr_len_q <= entry_len(first_state(chan, powered_q), setup_b_q);
            end
          end
        endcase
      end
    end
  end

  // Converter stays warm only under the always-on policy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      powered_q <= 1'b0;
    end else if (pwr != PWR_ON) begin
      powered_q <= 1'b0;
    end else if ((state_q == ST_ACQUIRE) && tmr_bus.expired) begin
      powered_q <= 1'b1;
    end
  end

  // Conversion start pulse at the end of acquisition, unless a restart or abort overrides it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sar_start_q <= 1'b0;
    end else begin
      sar_start_q <= (state_q == ST_ACQUIRE) && tmr_bus.expired && !start_req && !stop_req;
    end
  end

  // Averaging accumulator and remaining count
  assign acc_next = acc_q + {4'h0, sar_result_i};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avg_left_q <= 5'h01;
      acc_q <= 16'h0000;
    end else if (start_req || ((state_q == ST_REPEAT) && tmr_bus.expired)
                 || last_done) begin
      avg_left_q <= avg_count(setup_b_q[`AVERAGE_LSB+:2]);
      acc_q <= 16'h0000;
    end else if ((state_q == ST_CONVERT) && sar_done_i) begin
      avg_left_q <= avg_left_q - 5'h01;
      acc_q <= acc_next;
    end
  end

  // Mean of the run; the counts are powers of two
  always_comb begin
    avg_shifted = acc_next;
    unique case (setup_b_q[`AVERAGE_LSB+:2])
      2'b00: avg_shifted = acc_next;
      2'b01: avg_shifted = acc_next >> 2;
      2'b10: avg_shifted = acc_next >> 3;
      2'b11: avg_shifted = acc_next >> 4;
    endcase
  end

  // One result register per channel code 0 to 10
  generate
    for (genvar i = 0; i < `RESULT_COUNT; i++) begin : g_result
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          result_q[i] <= 12'h000;
        end else if (last_done && (chan == 4'(i))) begin
          result_q[i] <= avg_shifted[11:0];
        end
      end
    end
  endgenerate

  // Readback through the pointer field
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q <= 12'h000;
    end else if (reg_rd_i) begin
      if (setup_a_q[`PTR_MSB:`PTR_LSB] == `PTR_SETUP_A) begin
        rd_data_q <= setup_a_q;
      end else if (setup_a_q[`PTR_MSB:`PTR_LSB] == `PTR_SETUP_B) begin
        rd_data_q <= setup_b_q;
      end else if ((setup_a_q[`PTR_MSB:`PTR_LSB] >= `PTR_RESULT_BASE)
                   && (setup_a_q[`PTR_MSB:`PTR_LSB]
                       < (`PTR_RESULT_BASE + 5'(`RESULT_COUNT)))) begin
        rd_data_q <= result_q[4'(setup_a_q[`PTR_MSB:`PTR_LSB] - `PTR_RESULT_BASE)];
      end else begin
        rd_data_q <= 12'h000;
      end
    end
  end

  // Power, sampling and precharge pin drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_power_q <= 1'b0;
      ref_power_q <= 1'b0;
      sample_q <= 1'b0;
      precharge_q <= 1'b0;
    end else begin
      unique case (pwr)
        PWR_OFF: adc_power_q <= 1'b0;
        PWR_ON: adc_power_q <= 1'b1;
        PWR_CONV, PWR_ADC_CONV: adc_power_q <= (state_q == ST_SETTLE)
            || (state_q == ST_ACQUIRE) || (state_q == ST_CONVERT);
      endcase
      unique case (pwr)
        PWR_OFF: ref_power_q <= 1'b0;
        PWR_ON, PWR_ADC_CONV: ref_power_q <= !setup_b_q[`REF_EXT_BIT];
        PWR_CONV: ref_power_q <= !setup_b_q[`REF_EXT_BIT] && ((state_q == ST_SETTLE)
            || (state_q == ST_ACQUIRE) || (state_q == ST_CONVERT));
      endcase
      sample_q <= (state_q == ST_ACQUIRE);
      precharge_q <= (state_q == ST_PRECHARGE);
    end
  end

  // Outputs
  assign reg_rd_data_o = rd_data_q;
  assign sar_start_o = sar_start_q;
  assign sample_o = sample_q;
  assign channel_select_o = setup_a_q[`CHAN_MSB:`CHAN_LSB];
  assign single_ended_select_o = setup_a_q[`SINGLE_ENDED_BIT];
  assign ref_external_o = setup_b_q[`REF_EXT_BIT];
  assign adc_power_o = adc_power_q;
  assign ref_power_o = ref_power_q;
  assign touch_irq_precharge_o = precharge_q;
  assign busy_o = (state_q != ST_IDLE);
endmodule

// ===== logic/unused_placeholder_none.sv
// Intentionally empty design unit
`timescale 1ns/1ps

// ===== tb/touch_adc_control_props.sv
// Checker for the converter control registers and sequencer, bound to the top module
`timescale 1ns/1ps
module touch_adc_control_props
  import touch_adc_pkg::*;
#(
  parameter int TICK_CYCLES = 100
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_wr_addr_i,
  input wire logic [11:0] reg_wr_data_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_rd_data_o,
  // Converter and pins
  input wire logic sample_o,
  input wire logic [3:0] channel_select_o,
  input wire logic single_ended_select_o,
  input wire logic ref_external_o,
  input wire logic adc_power_o,
  input wire logic ref_power_o,
  input wire logic acquisition_hold_pin_i,
  input wire logic busy_o
);
  logic [11:0] shad_a_q;
  logic [11:0] shad_b_q;
  logic [15:0] samp_cnt_q;
  logic [15:0] samp_exp;
  logic held_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow copies of both registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shad_a_q <= 12'h000;
      shad_b_q <= 12'h000;
    end else if (reg_wr_i && reg_wr_addr_i == 4'h1) begin
      shad_a_q <= reg_wr_data_i;
    end else if (reg_wr_i && reg_wr_addr_i == 4'h2) begin
      shad_b_q <= reg_wr_data_i;
    end
  end

  // Length of the acquisition phase and whether the hold pin paused it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_cnt_q <= 16'h0000;
      held_q <= 1'b0;
    end else begin
      samp_cnt_q <= sample_o ? samp_cnt_q + 16'h0001 : 16'h0000;
      if (!busy_o) held_q <= 1'b0;
      else if (acquisition_hold_pin_i == shad_b_q[3]) held_q <= 1'b1;
    end
  end
  assign samp_exp = 16'(TICK_CYCLES) << ({1'b0, shad_b_q[9:8]} + 3'h2);

  // Writes to either register, starts, aborts and refused starts
  sequence wr_a_s;
    reg_wr_i && reg_wr_addr_i == 4'h1;
  endsequence
  sequence wr_b_s;
    reg_wr_i && reg_wr_addr_i == 4'h2;
  endsequence
  sequence start_s;
    reg_wr_i && reg_wr_addr_i == 4'h1 && reg_wr_data_i[1:0] != 2'b00 &&
      shad_b_q[7:6] != 2'b00 && !(reg_wr_data_i[1:0] == 2'b11 && shad_b_q[7:6] == 2'b10);
  endsequence
  sequence abort_s;
    reg_wr_i && reg_wr_addr_i == 4'h1 && reg_wr_data_i[1:0] == 2'b00;
  endsequence
  sequence refuse_s;
    reg_wr_i && reg_wr_addr_i == 4'h1 && !busy_o && (shad_b_q[7:6] == 2'b00 ||
      (reg_wr_data_i[1:0] == 2'b11 && shad_b_q[7:6] == 2'b10));
  endsequence

  chan_select_a: assert property (
    wr_a_s |=> channel_select_o == $past(reg_wr_data_i[10:7])) else $error("channel mismatch");
  conv_type_a: assert property (
    wr_a_s |=> single_ended_select_o == $past(reg_wr_data_i[11])) else $error("type mismatch");
  ref_select_a: assert property (
    wr_b_s |=> ref_external_o == $past(reg_wr_data_i[2])) else $error("ref select mismatch");
  readback_first_a: assert property (
    reg_rd_i && !reg_wr_i && shad_a_q[6:2] == 5'h01 |=> reg_rd_data_o == $past(shad_a_q))
    else $error("first register readback wrong");
  readback_second_a: assert property (
    reg_rd_i && !reg_wr_i && shad_a_q[6:2] == 5'h02 |=> reg_rd_data_o == $past(shad_b_q))
    else $error("second register readback wrong");
  run_start_a: assert property (
    start_s |=> busy_o) else $error("start not taken");
  run_abort_a: assert property (
    abort_s |=> !busy_o) else $error("abort not taken");
  start_refused_a: assert property (
    refuse_s |=> !busy_o) else $error("refused start ran");
  sample_length_a: assert property (
    $fell(sample_o) && busy_o && !held_q |->
      samp_cnt_q + 16'h0001 >= samp_exp && samp_cnt_q <= samp_exp + 16'h0002)
    else $error("acquisition length wrong");
  ext_ref_off_a: assert property (
    ref_external_o && $past(ref_external_o) |-> !ref_power_o)
    else $error("internal reference on");
  power_off_a: assert property (
    shad_b_q[7:6] == 2'b00 && $past(shad_b_q[7:6]) == 2'b00 |-> !adc_power_o && !ref_power_o)
    else $error("power on under policy off");
  power_on_a: assert property (
    shad_b_q[7:6] == 2'b10 && $past(shad_b_q[7:6]) == 2'b10 |-> adc_power_o)
    else $error("converter off under policy on");
endmodule

bind touch_adc_control touch_adc_control_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_wr_addr_i(reg_wr_addr_i),
  .reg_wr_data_i(reg_wr_data_i), .reg_rd_i(reg_rd_i), .reg_rd_data_o(reg_rd_data_o),
  .sample_o(sample_o), .channel_select_o(channel_select_o),
  .single_ended_select_o(single_ended_select_o), .ref_external_o(ref_external_o),
  .adc_power_o(adc_power_o), .ref_power_o(ref_power_o),
  .acquisition_hold_pin_i(acquisition_hold_pin_i), .busy_o(busy_o));

// ===== tb/sar_model.sv
// Behavioural successive approximation converter answering start pulses
`timescale 1ns/1ps
module sar_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control side
  input wire logic start_i,
  input wire logic [3:0] latency_i,
  input wire logic [11:0] value_i,
  // Answer
  output logic done_o,
  output logic [11:0] result_o
);
  logic [4:0] wait_q;
  // Count down the latency, then present the value for one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 5'h00;
      done_o <= 1'b0;
      result_o <= 12'h000;
    end else begin
      done_o <= (wait_q == 5'h01);
      result_o <= (wait_q == 5'h01) ? value_i : ~result_o; // Toggles while not valid
      if (start_i) wait_q <= {1'b0, latency_i} + 5'h01;
      else if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
    end
  end
endmodule

// ===== tb/touch_adc_control_tb.sv
// Self-checking bench of the converter control registers and sequencer
`timescale 1ns/1ps
module touch_adc_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [3:0] reg_wr_addr_i = 4'h0;
  logic [11:0] reg_wr_data_i = 12'h000;
  logic reg_rd_i = 1'b0;
  logic hold_i = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [11:0] val = 12'h000;
  logic [11:0] rd_o, res;
  logic [3:0] ch_o;
  logic start_o, done, samp_o, se_o, ext_o, adc_o, refp_o, pre_o, busy_o;
  logic [11:0] pwr_b [6] = '{12'h008, 12'h048, 12'h088, 12'h0C8, 12'h0CC, 12'h08C};
  logic [1:0] pwr_e [6] = '{2'b00, 2'b00, 2'b11, 2'b01, 2'b00, 2'b10};
  int bad_count = 0;
  int cmp_count = 0;
  int starts = 0;
  int pre_len = 0;
  int n;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // Count converter starts and precharge cycles
  always @(posedge clk_i) begin
    if (start_o === 1'b1) starts++;
    if (pre_o === 1'b1) pre_len++;
  end

  touch_adc_control #(.TICK_CYCLES(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_wr_addr_i(reg_wr_addr_i),
    .reg_wr_data_i(reg_wr_data_i), .reg_rd_i(reg_rd_i), .reg_rd_data_o(rd_o),
    .sar_start_o(start_o), .sar_done_i(done), .sar_result_i(res), .sample_o(samp_o),
    .channel_select_o(ch_o), .single_ended_select_o(se_o), .ref_external_o(ext_o),
    .adc_power_o(adc_o), .ref_power_o(refp_o), .acquisition_hold_pin_i(hold_i),
    .touch_irq_precharge_o(pre_o), .busy_o(busy_o));

  sar_model i_sar (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_o), .latency_i(lat),
    .value_i(val), .done_o(done), .result_o(res));

  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_wr_addr_i = a;
    reg_wr_data_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input string nm, input logic [11:0] e);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(nm, {4'h0, e}, {4'h0, rd_o});
  endtask

  task automatic wait_idle(input int bound);
    int k;
    k = 0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && k < bound) begin
      @(negedge clk_i);
      k++;
    end
    chk("idle", 16'h0000, {15'h0000, busy_o});
    if (k >= bound) report_and_stop();
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    chk("reset_outputs", 16'h0000, {ch_o, se_o, ext_o, adc_o, refp_o, busy_o});
    wr(4'h1, 12'h008);
    rd("setup_b_reset", 12'h000);
    wr(4'h1, 12'h000);
    rd("pointer_none", 12'h000);
    wr(4'h1, 12'h06C);
    rd("pointer_unmapped", 12'h000);
    wr(4'h2, 12'hABC);
    wr(4'h1, 12'hD08);
    rd("setup_b", 12'hABC);
    chk("fields", 16'h0015, {ch_o, se_o});
    wr(4'h1, 12'hD04);
    rd("setup_a", 12'hD04);
    // Power policies with both references
    for (int i = 0; i < 6; i++) begin
      wr(4'h2, pwr_b[i]);
      repeat (3) @(negedge clk_i);
      chk("power", {14'h0000, pwr_e[i]}, {14'h0000, adc_o, refp_o});
      chk("ref_select", {15'h0000, pwr_b[i][2]}, {15'h0000, ext_o});
    end
    wr(4'h2, 12'h008);
    wr(4'h1, 12'h001);
    chk("busy_policy_off", 16'h0000, {15'h0000, busy_o});
    wr(4'h2, 12'h088);
    wr(4'h1, 12'h003);
    chk("busy_master_on", 16'h0000, {15'h0000, busy_o});
    // Every operation code, converting once except under the idle code
    wr(4'h2, 12'h048);
    for (int op = 0; op < 4; op++) begin
      starts = 0;
      wr(4'h1, {1'b1, 4'h3, 5'h13, 2'(op)});
      wait_idle(2000);
      chk("rounds", (op != 0) ? 16'h0001 : 16'h0000, 16'(starts));
    end
    // Master sequencing with two repeat intervals, each ended by an abort
    for (int t = 1; t < 3; t++) begin
      wr(4'h2, {10'h012, 2'(t)});
      starts = 0;
      wr(4'h1, {1'b1, 4'h3, 5'h13, 2'b11});
      for (n = 0; n < 6000 && starts < 2; n++) @(negedge clk_i);
      chk("interval", 16'h0001, {15'h0000, n >= 2048 * t && n <= 2048 * t + 152});
      if (starts < 2) report_and_stop();
      wr(4'h1, {1'b1, 4'h3, 5'h13, 2'b00});
      chk("aborted", 16'h0000, {15'h0000, busy_o});
    end
    // Every channel with averaging, sample time and converter latency varied
    for (int c = 0; c < 11; c++) begin
      lat = 4'(c);
      val = {8'hA5, 4'(c)};
      wr(4'h2, {2'(c), 2'(c >> 1), 8'h48});
      starts = 0;
      wr(4'h1, {1'(c), 4'(c), 5'(16 + c), 2'b01});
      chk("channel", 16'(c), {12'h000, ch_o});
      chk("conv_type", 16'(c % 2), {15'h0000, se_o});
      wait_idle(5000);
      chk("averages", (c % 4 == 0) ? 16'h0001 : 16'(2 << (c % 4)), 16'(starts));
      rd("result", {8'hA5, 4'(c)});
    end
    // Hold pin active low stalls acquisition
    lat = 4'h0;
    wr(4'h2, 12'h040);
    starts = 0;
    wr(4'h1, {1'b1, 4'h3, 5'h13, 2'b01});
    repeat (200) @(negedge clk_i);
    chk("stalled", 16'h0000, 16'(starts));
    hold_i = 1'b1;
    wait_idle(2000);
    chk("resumed", 16'h0001, 16'(starts));
    hold_i = 1'b0;
    // Precharge delay for settle codes
    for (int k = 0; k < 3; k++) begin
      wr(4'h2, {4'h0, 2'b01, 2'(k), 4'h8});
      pre_len = 0;
      wr(4'h1, {1'b1, 4'h3, 5'h13, 2'b01});
      wait_idle(10000);
      repeat (3) @(negedge clk_i);
      n = (k == 0) ? 2 : ((k == 1) ? 512 : 4096);
      chk("precharge", 16'h0001, {15'h0000, pre_len >= n - 1 && pre_len <= n + 2});
    end
    report_and_stop();
  end
endmodule
